// [hw/lsel_ahb_slave.sv]
// AHB-Lite slave front end: zero wait states, OKAY only, one word per register.
// Assumes the top supplies read data combinationally for the address-phase index.
`timescale 1ns/100ps
`default_nettype none
module lsel_ahb_slave
    import lsel_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    input  wire logic [31:0] rd_value,
    output var  logic [7:0]  rd_idx,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  lsel_regwr_t regwr
);
    logic       take;
    logic       pend_wr;
    logic [7:0] pend_idx;

    // Only aligned word transfers inside the index window reach registers
    assign take   = hsel && hready && htrans[1] && (haddr[1:0] == 2'b00)
                    && (hsize == 3'b010)
                    && (haddr[31:LSEL_IDX_W+LSEL_BYTE_SHIFT] == '0);
    assign rd_idx = haddr[LSEL_IDX_W+LSEL_BYTE_SHIFT-1:LSEL_BYTE_SHIFT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_wr  <= 1'b0;
            pend_idx <= '0;
        end else if (hready) begin
            pend_wr  <= take && hwrite;
            pend_idx <= rd_idx;
        end
    end

    // Read data is captured at the address phase so it stands in the data phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= '0;
        end else if (hready) begin
            hrdata <= (take && !hwrite) ? rd_value : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_comb begin
        regwr.wr    = pend_wr;
        regwr.idx   = pend_idx;
        regwr.wdata = hwdata;
    end
endmodule : lsel_ahb_slave
`default_nettype wire

// [hw/lsel_minute_tick.sv]
// Divider that produces a one-cycle enable once per minute.
// Assumes a free-running clock; the period is a parameter so benches can shorten it.
`timescale 1ns/100ps
`default_nettype none
module lsel_minute_tick
    import lsel_pkg::*;
#(
    parameter longint unsigned PERIOD = LSEL_MINUTE_CYCLES,
    parameter int              CNT_W  = LSEL_MINUTE_CNT_W
) (
    input  wire logic clk,
    input  wire logic rst,
    output var  logic tick
);
    logic [CNT_W-1:0] count;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (count == CNT_W'(PERIOD - 1)) begin
            count <= '0;
            tick  <= 1'b1;
        end else begin
            count <= count + CNT_W'(1);
            tick  <= 1'b0;
        end
    end
endmodule : lsel_minute_tick
`default_nettype wire

// [hw/lsel_pkg.sv]
// Constants and types shared by the legacy SMI event logic.
// Assumes a 250 MHz single clock and an AHB-Lite register port with 32-bit data.
package lsel_pkg;

    // ****************************************************************
    // Register indices and byte addresses
    // ****************************************************************
    localparam logic [7:0] LSEL_IDX_LEVEL    = 8'h3A;
    localparam logic [7:0] LSEL_IDX_DIR      = 8'h3C;
    localparam logic [7:0] LSEL_IDX_POL      = 8'h3E;
    localparam logic [7:0] LSEL_IDX_STATUS   = 8'h40;
    localparam logic [7:0] LSEL_IDX_ENABLE   = 8'h42;
    localparam logic [7:0] LSEL_IDX_TRAP0    = 8'h50;
    localparam logic [7:0] LSEL_IDX_TRAP1    = 8'h51;
    localparam int         LSEL_IDX_W        = 8;
    localparam int         LSEL_BYTE_SHIFT   = 2;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] LSEL_DIR_RST     = 16'hFFFF;
    localparam logic [15:0] LSEL_POL_RST     = 16'h0000;
    localparam logic [15:0] LSEL_LEVEL_RST   = 16'h0000;
    localparam logic [15:0] LSEL_STATUS_RST  = 16'h0000;
    localparam logic [15:0] LSEL_ENABLE_RST  = 16'h0000;
    localparam logic [31:0] LSEL_TRAP_RST    = 32'h0000_0000;

    // ****************************************************************
    // Status and enable field positions
    // ****************************************************************
    localparam int LSEL_B_WDT2    = 15;
    localparam int LSEL_B_WDT1    = 14;
    localparam int LSEL_B_GPE     = 13;
    localparam int LSEL_B_PM1     = 12;
    localparam int LSEL_B_SIRQ    = 9;
    localparam int LSEL_B_LPC     = 8;
    localparam int LSEL_B_MINUTE  = 7;
    localparam int LSEL_B_CENTURY = 6;
    localparam int LSEL_B_CMD     = 5;
    localparam int LSEL_B_FW      = 4;
    localparam int LSEL_B_TRAP1   = 3;
    localparam int LSEL_B_TRAP0   = 2;
    localparam int LSEL_B_USB     = 1;
    localparam int LSEL_B_SMI     = 0;
    localparam logic [15:0] LSEL_STATUS_RW_MASK = 16'hF3FF;
    localparam logic [15:0] LSEL_ENABLE_RW_MASK = 16'h03FF;
    localparam logic [15:0] LSEL_ENABLED_SRC    = 16'h03FE;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam longint unsigned LSEL_CLK_HZ        = 250_000_000;
    localparam longint unsigned LSEL_MINUTE_S      = 60;
    localparam longint unsigned LSEL_MINUTE_CYCLES = LSEL_MINUTE_S * LSEL_CLK_HZ;
    localparam int              LSEL_MINUTE_CNT_W  = 34;
    localparam logic [7:0]      LSEL_MASK_CYCLES   = 8'h80;

    // ****************************************************************
    // Event inputs from neighbouring blocks, each a one-cycle pulse
    // ****************************************************************
    typedef struct packed {
        logic wdt_second_expiry;
        logic wdt_first_expiry;
        logic gpe_smi;
        logic pm1_smi;
        logic sirq_smi;
        logic lpc_smi;
        logic century_wrap;
        logic command_port_write;
        logic global_release_write;
        logic legacy_usb_smi;
    } lsel_event_t;

    typedef struct packed {
        logic        wr;
        logic [7:0]  idx;
        logic [31:0] wdata;
    } lsel_regwr_t;

endpackage : lsel_pkg

// [hw/lsel_top.sv]
// Legacy SMI event logic: pin direction and polarity, sticky legacy status,
// enables and the SMI output with its post-clear masking window.
// Assumes RST is the PCI bus reset and RESUME_RST the standby-well reset.
//
// Behaviour
// - Sixteen direction bits, zero selects output, all reset to one.
// - Sixteen input polarity bits, one is active high, reset to zero.
// - Status bits stick; only writing one clears them, zero writes do nothing.
// - Bit 15 sets on the second watchdog expiry.
// - Bit 14 sets on the first watchdog expiry.
// - Watchdog flags have no enable and survive the PCI bus reset.
// - Bit 13 sets when an event group requests SMI; no enable.
// - Bit 12 sets when the power-management group requests SMI; no enable.
// - Bit 9 sets on serial interrupt SMI request; bits 11:10 reserved.
// - Bit 8 sets on low-pin-count controller SMI request.
// - Bit 7 sets once every minute.
// - Bit 6 sets when the clock year wraps from 99 to 00.
// - Bit 5 sets on any write to the SMI command port.
// - Bit 4 sets when software writes one to the global release bit.
// - Bits 3 and 2 set on I/O accesses inside each trap window.
// - Bit 1 sets on a legacy USB SMI request.
// - Bit 0 sets on any enabled flag of bits 9:1 or on bit 13 or 12; clearing it masks SMI 128 clocks.
// - Enable bits 9:0 are read-write, 15:10 reserved, all reset to zero.
// - Pins in output mode report no event; software keeps their enables zero.
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module lsel_top
    import lsel_pkg::*;
#(
    parameter longint unsigned MINUTE_CYCLES = LSEL_MINUTE_CYCLES,
    parameter int              PINS          = 16
) (
    input  wire logic            CLK,
    input  wire logic            RST,
    input  wire logic            RESUME_RST,
    input  wire logic            HSEL,
    input  wire logic [31:0]     HADDR,
    input  wire logic [1:0]      HTRANS,
    input  wire logic            HWRITE,
    input  wire logic [2:0]      HSIZE,
    input  wire logic            HREADY,
    input  wire logic [31:0]     HWDATA,
    output var  logic [31:0]     HRDATA,
    output var  logic            HREADYOUT,
    output var  logic            HRESP,
    input  wire lsel_event_t     EVENTS,
    input  wire logic            IO_ACCESS,
    input  wire logic [15:0]     IO_ADDR,
    input  wire logic [PINS-1:0] GPIO_IN,
    output var  logic [PINS-1:0] GPIO_OUT,
    output var  logic [PINS-1:0] GPIO_OE_N,
    output var  logic [PINS-1:0] GPIO_EVENT,
    output var  logic            SMI_N
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic trap_hit(input logic [15:0] addr, input logic [31:0] cfg);
        // Low half is the base port, high half marks address bits to ignore
        trap_hit = ((addr ^ cfg[15:0]) & ~cfg[31:16]) == 16'h0000;
    endfunction : trap_hit

    function automatic logic is_write(input lsel_regwr_t w, input logic [7:0] idx);
        is_write = w.wr && (w.idx == idx);
    endfunction : is_write

    // ****************************************************************
    // Bus front end
    // ****************************************************************
    lsel_regwr_t      regwr;
    logic [7:0]       rd_idx;
    logic [31:0]      rd_value;
    logic             minute_tick;

    lsel_ahb_slave u_bus (
        .clk       (CLK),
        .rst       (RST),
        .hsel      (HSEL),
        .haddr     (HADDR),
        .htrans    (HTRANS),
        .hwrite    (HWRITE),
        .hsize     (HSIZE),
        .hready    (HREADY),
        .hwdata    (HWDATA),
        .rd_value  (rd_value),
        .rd_idx    (rd_idx),
        .hrdata    (HRDATA),
        .hreadyout (HREADYOUT),
        .hresp     (HRESP),
        .regwr     (regwr)
    );

    lsel_minute_tick #(
        .PERIOD (MINUTE_CYCLES),
        .CNT_W  (LSEL_MINUTE_CNT_W)
    ) u_minute (
        .clk  (CLK),
        .rst  (RST),
        .tick (minute_tick)
    );

    // ****************************************************************
    // Pin control registers
    // ****************************************************************
    logic [PINS-1:0] direction;
    logic [PINS-1:0] polarity;
    logic [PINS-1:0] level;
    logic [31:0]     trap_zero_cfg;
    logic [31:0]     trap_one_cfg;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            direction <= LSEL_DIR_RST[PINS-1:0];
        end else if (is_write(regwr, LSEL_IDX_DIR)) begin
            direction <= regwr.wdata[PINS-1:0];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            polarity <= LSEL_POL_RST[PINS-1:0];
        end else if (is_write(regwr, LSEL_IDX_POL)) begin
            polarity <= regwr.wdata[PINS-1:0];
        end
    end

    // The level must be loaded before a pin turns to output, else it drives stale data
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            level <= LSEL_LEVEL_RST[PINS-1:0];
        end else if (is_write(regwr, LSEL_IDX_LEVEL)) begin
            level <= regwr.wdata[PINS-1:0];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            trap_zero_cfg <= LSEL_TRAP_RST;
            trap_one_cfg  <= LSEL_TRAP_RST;
        end else begin
            if (is_write(regwr, LSEL_IDX_TRAP0)) begin
                trap_zero_cfg <= regwr.wdata;
            end
            if (is_write(regwr, LSEL_IDX_TRAP1)) begin
                trap_one_cfg <= regwr.wdata;
            end
        end
    end

    // Pin drive and normalised event level; output-mode pins never report events
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            GPIO_OUT   <= LSEL_LEVEL_RST[PINS-1:0];
            GPIO_OE_N  <= LSEL_DIR_RST[PINS-1:0];
            GPIO_EVENT <= '0;
        end else begin
            GPIO_OUT   <= level;
            GPIO_OE_N  <= direction;
            GPIO_EVENT <= ~(GPIO_IN ^ polarity) & direction;
        end
    end

    // ****************************************************************
    // Legacy status and enable
    // ****************************************************************
    logic [15:0] status;
    logic [1:0]  wdt_status;
    logic [13:0] main_status;
    logic [15:0] enable;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic        smi_source;
    logic        smi_clear;
    logic [7:0]  mask_count;
    logic        smi_masked;

    assign clr_vec   = is_write(regwr, LSEL_IDX_STATUS) ? regwr.wdata[15:0] : 16'h0000;
    assign smi_clear = clr_vec[LSEL_B_SMI];

    // Two reset domains, so each owns its own variable and the word is joined here
    assign status    = {wdt_status, main_status};

    // Any enabled flag, or the two group flags that have no enable
    assign smi_source = |(status & enable & LSEL_ENABLED_SRC)
                        | status[LSEL_B_GPE] | status[LSEL_B_PM1];

    always_comb begin
        set_vec                 = 16'h0000;
        set_vec[LSEL_B_WDT2]    = EVENTS.wdt_second_expiry;
        set_vec[LSEL_B_WDT1]    = EVENTS.wdt_first_expiry;
        set_vec[LSEL_B_GPE]     = EVENTS.gpe_smi;
        set_vec[LSEL_B_PM1]     = EVENTS.pm1_smi;
        set_vec[LSEL_B_SIRQ]    = EVENTS.sirq_smi;
        set_vec[LSEL_B_LPC]     = EVENTS.lpc_smi;
        set_vec[LSEL_B_MINUTE]  = minute_tick;
        set_vec[LSEL_B_CENTURY] = EVENTS.century_wrap;
        set_vec[LSEL_B_CMD]     = EVENTS.command_port_write;
        set_vec[LSEL_B_FW]      = EVENTS.global_release_write;
        set_vec[LSEL_B_TRAP1]   = IO_ACCESS && trap_hit(IO_ADDR, trap_one_cfg);
        set_vec[LSEL_B_TRAP0]   = IO_ACCESS && trap_hit(IO_ADDR, trap_zero_cfg);
        set_vec[LSEL_B_USB]     = EVENTS.legacy_usb_smi;
        set_vec[LSEL_B_SMI]     = smi_source;
    end

    // Watchdog flags live in the standby well so a PCI reset cannot erase the evidence
    always_ff @(posedge CLK or posedge RESUME_RST) begin
        if (RESUME_RST) begin
            wdt_status <= LSEL_STATUS_RST[15:14];
        end else begin
            wdt_status <= (wdt_status & ~clr_vec[15:14]) | set_vec[15:14];
        end
    end

    // Set wins over a simultaneous clear
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            main_status <= LSEL_STATUS_RST[13:0];
        end else begin
            main_status <= ((main_status & ~clr_vec[13:0]) | set_vec[13:0])
                           & LSEL_STATUS_RW_MASK[13:0];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            enable <= LSEL_ENABLE_RST;
        end else if (is_write(regwr, LSEL_IDX_ENABLE)) begin
            enable <= regwr.wdata[15:0] & LSEL_ENABLE_RW_MASK;
        end
    end

    // ****************************************************************
    // SMI output and masking window
    // ****************************************************************
    // Summary enable gates the line as a whole; the group flags need no enable
    // The window gives the handler time to leave before a new SMI fires
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mask_count <= '0;
        end else if (smi_clear) begin
            mask_count <= LSEL_MASK_CYCLES;
        end else if (mask_count != '0) begin
            mask_count <= mask_count - 8'h01;
        end
    end

    assign smi_masked = (mask_count != '0);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SMI_N <= 1'b1;
        end else begin
            SMI_N <= ~(smi_source && enable[LSEL_B_SMI] && !smi_masked
                       && !smi_clear);
        end
    end

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    // Unmapped indices read as zero so software can probe without side effects
    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (rd_idx)
            LSEL_IDX_LEVEL:  rd_value[PINS-1:0] = (direction & GPIO_IN) | (~direction & level);
            LSEL_IDX_DIR:    rd_value[PINS-1:0] = direction;
            LSEL_IDX_POL:    rd_value[PINS-1:0] = polarity;
            LSEL_IDX_STATUS: rd_value[15:0]     = status;
            LSEL_IDX_ENABLE: rd_value[15:0]     = enable;
            LSEL_IDX_TRAP0:  rd_value           = trap_zero_cfg;
            LSEL_IDX_TRAP1:  rd_value           = trap_one_cfg;
            default:         rd_value           = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_status_sticky: assert property (
        $past(status[LSEL_B_CMD]) && !$past(clr_vec[LSEL_B_CMD]) |-> status[LSEL_B_CMD])
        else $error("status flag dropped without a clear");
    a_zero_write_keeps: assert property (
        is_write(regwr, LSEL_IDX_STATUS) && regwr.wdata[15:0] == 16'h0000
        |=> status[13:0] == ($past(status[13:0]) | $past(set_vec[13:0])))
        else $error("zero write changed status");
    a_set_beats_clear: assert property (
        EVENTS.command_port_write |=> status[LSEL_B_CMD])
        else $error("command port write lost");
    a_wdt_flags: assert property (
        EVENTS.wdt_second_expiry && !RESUME_RST |=> status[LSEL_B_WDT2])
        else $error("second expiry not flagged");
    a_reserved_zero: assert property (
        status[11:10] == 2'b00 && enable[15:10] == 6'h00)
        else $error("reserved bits set");
    a_trap_flag: assert property (
        IO_ACCESS && trap_hit(IO_ADDR, trap_zero_cfg) |=> status[LSEL_B_TRAP0])
        else $error("trap zero access missed");
    a_mask_window: assert property (
        smi_clear |=> (SMI_N && mask_count == 8'h80) ##1 SMI_N [*8])
        else $error("SMI not masked after clear");
    a_mask_length: assert property (
        mask_count == 8'h01 && !smi_clear |=> mask_count == 8'h00)
        else $error("mask window wrong length");
    a_smi_assert: assert property (
        smi_source && enable[LSEL_B_SMI] && !smi_masked && !smi_clear |=> !SMI_N)
        else $error("SMI not raised for enabled source");
    a_pin_output_quiet: assert property (
        !direction[0] |=> !GPIO_EVENT[0] && !GPIO_OE_N[0])
        else $error("output pin reported event");
    a_polarity_high: assert property (
        direction[0] && polarity[0] && GPIO_IN[0] |=> GPIO_EVENT[0])
        else $error("active-high pin not reported");
    a_wdt_survive: assert property (@(posedge CLK) disable iff (RESUME_RST)
        RST && status[LSEL_B_WDT2] |=> status[LSEL_B_WDT2])
        else $error("watchdog flag lost in bus reset");
    a_enable_write: assert property (
        is_write(regwr, LSEL_IDX_ENABLE)
        |=> enable == ($past(regwr.wdata[15:0]) & LSEL_ENABLE_RW_MASK))
        else $error("enable write not applied");
    a_minute_flag: assert property (
        minute_tick |=> status[LSEL_B_MINUTE])
        else $error("minute tick not flagged");
    a_summary_set: assert property (
        smi_source |=> status[LSEL_B_SMI])
        else $error("summary flag not set for active source");
    a_gpe_flag: assert property (
        EVENTS.gpe_smi |=> status[LSEL_B_GPE])
        else $error("event group request not flagged");
    a_usb_flag: assert property (
        EVENTS.legacy_usb_smi |=> status[LSEL_B_USB])
        else $error("legacy USB request not flagged");

    c_smi_raised:   cover property (!SMI_N);
    c_smi_cleared:  cover property (smi_clear ##1 smi_masked [*3]);
    c_minute_tick:  cover property (minute_tick);
    c_trap_one_hit: cover property (set_vec[LSEL_B_TRAP1]);
    c_enable_all:   cover property (enable == LSEL_ENABLE_RW_MASK);

endmodule : lsel_top
`default_nettype wire

// [test/legacy_smi_event_logic_bench.sv]
// Self-checking bench for the legacy SMI event logic top.
// Assumes a one-slave AHB-Lite bus and a shortened minute period.
`timescale 1ns/100ps
`default_nettype none
module legacy_smi_event_logic_bench;
    import lsel_pkg::*;
    localparam int MIN_CYC = 50;
    localparam int POS[10] = '{1, 4, 5, 6, 8, 9, 12, 13, 14, 15};
    logic        clk = 1'b0, rst = 1'b1, rrst = 1'b1, hsel = 1'b0;
    logic        hwrite = 1'b0, io_acc = 1'b0, hready, hresp, smi_n;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'hBBABE6C3;
    logic [15:0] io_addr = 16'h0, gin = 16'h0, gout, goe_n, gevt, pol, port;
    logic [7:0]  smi_cycles;
    lsel_event_t ev = '0;
    int          bad_count = 0, samples_checked = 0;
    always #2 clk = ~clk;
    lsel_top #(.MINUTE_CYCLES(MIN_CYC)) dut (.CLK(clk), .RST(rst), .RESUME_RST(rrst),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .EVENTS(ev), .IO_ACCESS(io_acc), .IO_ADDR(io_addr),
        .GPIO_IN(gin), .GPIO_OUT(gout), .GPIO_OE_N(goe_n), .GPIO_EVENT(gevt), .SMI_N(smi_n));
    lsel_host_model host (.clk(clk), .rst(rst), .smi_n(smi_n), .smi_cycles(smi_cycles));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [15:0] exp_evt(input logic [15:0] i, p, d);
        return ~(i ^ p) & d;
    endfunction : exp_evt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Entered just after an edge; read data is taken at the data-phase edge
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d);
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsel <= 1'b1;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    initial begin
        cyc(20000);
        bad_count++;
        report_and_stop();
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        cyc(20);
        rst <= 1'b0;
        rrst <= 1'b0;
        cyc(1);
        bus(LSEL_IDX_DIR, 0, 0); chk(rd, 32'h0000FFFF);
        bus(LSEL_IDX_POL, 0, 0); chk(rd, 32'h0);
        bus(LSEL_IDX_ENABLE, 0, 0); chk(rd, 32'h0);
        bus(8'h44, 1, 32'hFFFF); bus(8'h44, 0, 0); chk(rd, 32'h0);
        cyc(MIN_CYC); bus(LSEL_IDX_STATUS, 0, 0); chk(rd & 32'h80, 32'h80);
        pol = 16'(xs());
        gin <= 16'(xs());
        bus(LSEL_IDX_POL, 1, {16'h0, pol}); bus(LSEL_IDX_POL, 0, 0); chk(rd, {16'h0, pol});
        cyc(2); chk(32'(gevt), 32'(exp_evt(gin, pol, 16'hFFFF)));
        // Level first, so the newly driven pins never glitch
        bus(LSEL_IDX_LEVEL, 1, 32'hA5A5); bus(LSEL_IDX_DIR, 1, 32'hFF00); cyc(2);
        chk(32'(goe_n), 32'hFF00);
        chk(32'(gout & ~goe_n), 32'h00A5);
        chk(32'(gevt), 32'(exp_evt(gin, pol, 16'hFF00)));
        bus(LSEL_IDX_DIR, 1, 32'hFFFF);
        bus(LSEL_IDX_ENABLE, 1, 32'hFFFF); bus(LSEL_IDX_ENABLE, 0, 0); chk(rd, 32'h3FF);
        chk(32'(hresp), 32'h0);
        bus(LSEL_IDX_ENABLE, 1, 0); bus(LSEL_IDX_STATUS, 1, 32'hFFFF);
        for (int i = 0; i < 10; i++) begin
            ev <= lsel_event_t'(10'h1 << i);
            cyc(1);
            ev <= '0;
            bus(LSEL_IDX_STATUS, 1, 0); bus(LSEL_IDX_STATUS, 0, 0);
            chk(rd & (32'h1 << POS[i]), 32'h1 << POS[i]);
            bus(LSEL_IDX_STATUS, 1, (32'h1 << POS[i]) | 32'h1); bus(LSEL_IDX_STATUS, 0, 0);
            chk(rd & (32'h1 << POS[i]), 32'h0);
        end
        port = 16'(xs());
        bus(LSEL_IDX_TRAP0, 1, {16'h0, port}); bus(LSEL_IDX_TRAP1, 1, 32'hFFFF_0000);
        for (int j = 0; j < 2; j++) begin
            bus(LSEL_IDX_STATUS, 1, 32'hFFFF);
            io_addr <= (j == 1) ? port : ~port;
            io_acc <= 1'b1;
            cyc(1);
            io_acc <= 1'b0;
            bus(LSEL_IDX_STATUS, 0, 0); chk(rd & 32'hC, (j == 1) ? 32'hC : 32'h8);
        end
        bus(LSEL_IDX_STATUS, 1, 32'hFFFF); bus(LSEL_IDX_ENABLE, 1, 32'h3);
        // The clear above opened a mask window; let it run out first
        cyc(130);
        ev <= lsel_event_t'(10'h1);
        cyc(1);
        ev <= '0;
        cyc(4); chk(32'(smi_n), 32'h0);
        // Source stays pending, so only the mask window keeps the line quiet
        bus(LSEL_IDX_STATUS, 1, 32'h1);
        cyc(120); chk(32'(smi_n), 32'h1);
        cyc(15); chk(32'(smi_n), 32'h0);
        chk(32'(smi_cycles != 8'h00), 32'h1);
        bus(LSEL_IDX_STATUS, 1, 32'hFFFF); bus(LSEL_IDX_ENABLE, 1, 0);
        ev <= lsel_event_t'(10'h300);
        cyc(1);
        ev <= '0;
        cyc(2);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        bus(LSEL_IDX_STATUS, 0, 0); chk(rd & 32'hC000, 32'hC000);
        report_and_stop();
    end
endmodule : legacy_smi_event_logic_bench
`default_nettype wire

// [test/lsel_host_model.sv]
// Host processor model: counts cycles in which an SMI request is held.
// Assumes SMI_N is an active-low level driven from CLK.
`timescale 1ns/100ps
`default_nettype none
module lsel_host_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       smi_n,
    output var  logic [7:0] smi_cycles
);
    // Saturates so a long request never wraps back to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            smi_cycles <= 8'h00;
        end else if (!smi_n && smi_cycles != 8'hFF) begin
            smi_cycles <= smi_cycles + 8'h01;
        end
    end
endmodule : lsel_host_model
`default_nettype wire
